/* core/rx_cas_pkg.sv */
package rx_cas_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 10;
	localparam int BYTE_W = 8;
	localparam int STRB_W = DATA_W / BYTE_W;

	// ------------------------------------------------------------
	// Channel geometry
	// ------------------------------------------------------------
	localparam int NIB_W = 4;
	localparam int NUM_CH = 30;
	localparam int HALF_CH = 15;
	localparam int FRAME_W = 4;
	localparam int PAIR_W = 4;
	localparam int CH_IDX_W = 5;
	localparam logic [FRAME_W-1:0] MF_FRAME0 = 4'h0;
	localparam logic [PAIR_W-1:0] PAIR_FIRST = 4'h1;
	localparam logic [PAIR_W-1:0] PAIR_LAST = 4'hf;
	localparam logic [CH_IDX_W-1:0] HI_CH_OFFSET = 5'h01;
	localparam logic [CH_IDX_W-1:0] LO_CH_OFFSET = 5'h0e;

	// ------------------------------------------------------------
	// Register indexes; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] DB_MF_IDX = 10'h080;
	localparam logic [IDX_W-1:0] RX_SIG_CH7_CH22_IDX = 10'h087;
	localparam logic [IDX_W-1:0] RX_SIG_CH8_CH23_IDX = 10'h088;
	localparam logic [IDX_W-1:0] RX_SIG_CH9_CH24_IDX = 10'h089;
	localparam logic [IDX_W-1:0] RX_SIG_CH10_CH25_IDX = 10'h08a;
	localparam logic [IDX_W-1:0] RX_SIG_CH11_CH26_IDX = 10'h08b;
	localparam logic [IDX_W-1:0] RX_SIG_CH12_CH27_IDX = 10'h08c;
	localparam logic [IDX_W-1:0] RX_SIG_CH13_CH28_IDX = 10'h08d;
	localparam logic [IDX_W-1:0] RX_SIG_CH14_CH29_IDX = 10'h08e;
	localparam logic [IDX_W-1:0] RX_SIG_CH15_CH30_IDX = 10'h08f;
	localparam logic [IDX_W-1:0] ACTIVE1_MF_ALIGN_SPARE_IDX = 10'h137;
	localparam logic [IDX_W-1:0] ACTIVE1_SIG_CH1_CH16_IDX = 10'h138;
	localparam logic [IDX_W-1:0] CTRL_IDX = 10'h1f0;
	localparam logic [IDX_W-1:0] ENABLE_IDX = 10'h1f1;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int NIB_HI_LSB = 4;
	localparam int NIB_LO_LSB = 0;
	localparam int MFAS_LSB = 4;
	localparam int SPARE0_POS = 3;
	localparam int LOMF_POS = 2;
	localparam int SPARE1_POS = 1;
	localparam int SPARE2_POS = 0;
	// Slot bit n (1 = first received) sits at byte position 8 - n
	localparam int TS_MFAS_LSB = 4;
	localparam int TS_BIT5_POS = 3;
	localparam int TS_BIT6_POS = 2;
	localparam int TS_BIT7_POS = 1;
	localparam int TS_BIT8_POS = 0;
	localparam int CTRL_DEBOUNCE_POS = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [NUM_CH-1:0] ENABLE_RESET = 30'h00000000;
	localparam logic CTRL_DEBOUNCE_RESET = 1'b0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

endpackage

/* core/sig_nibble_cell.sv */
`timescale 1ns/1ps

module sig_nibble_cell
	import rx_cas_pkg::*;
#(
	parameter int W = NIB_W,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cpu_we,
	input wire logic [W-1:0] cpu_d,
	input wire logic line_we,
	input wire logic [W-1:0] line_d,
	output logic [W-1:0] q
);

	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// Software write wins a collision so a forced value is never lost
	assign q_next = cpu_we ? cpu_d : (line_we ? line_d : q_reg);
	assign q = q_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_reg <= RESET_VAL;
		end else begin
			q_reg <= q_next;
		end
	end

endmodule

/* core/rx_cas_signaling_buffer.sv */
`timescale 1ns/1ps


module rx_cas_signaling_buffer
	import rx_cas_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [STRB_W-1:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ts16_valid,
	input wire logic [FRAME_W-1:0] ts16_frame,
	input wire logic [BYTE_W-1:0] ts16_byte,
	output logic [NUM_CH*NIB_W-1:0] rx_highway_sig,
	output logic active1_valid
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] chan_rx_sig_update_enable_reg;
	logic [NUM_CH-1:0] chan_rx_sig_update_enable_next;
	logic debounce_select_reg;
	logic debounce_select_next;
	logic [BYTE_W-1:0] db_mf_reg;
	logic [BYTE_W-1:0] db_mf_next;
	logic [BYTE_W-1:0] a1_mf_reg;
	logic [BYTE_W-1:0] a1_mf_next;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic [NIB_W-1:0] db_q [NUM_CH];
	logic [NIB_W-1:0] a1_q [NUM_CH];

	// ------------------------------------------------------------
	// Slot 16 decode
	// ------------------------------------------------------------
	wire frame0_hit = ts16_valid && (ts16_frame == MF_FRAME0);
	wire [NIB_W-1:0] rx_hi_nib = ts16_byte[NIB_HI_LSB +: NIB_W];
	wire [NIB_W-1:0] rx_lo_nib = ts16_byte[NIB_LO_LSB +: NIB_W];

	// Frame 0 byte rebuilt field by field into the register layout
	wire [BYTE_W-1:0] frame0_fields;
	assign frame0_fields[MFAS_LSB +: NIB_W] = ts16_byte[TS_MFAS_LSB +: NIB_W];
	assign frame0_fields[SPARE0_POS] = ts16_byte[TS_BIT5_POS];
	assign frame0_fields[SPARE1_POS] = ts16_byte[TS_BIT7_POS];
	assign frame0_fields[SPARE2_POS] = ts16_byte[TS_BIT8_POS];
	assign frame0_fields[LOMF_POS] = ts16_byte[TS_BIT6_POS];

	// Spare and alarm bits bypass debounce in both buffers
	assign db_mf_next = frame0_hit ? frame0_fields : db_mf_reg;
	assign a1_mf_next = frame0_hit ? frame0_fields : a1_mf_reg;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire [IDX_W-1:0] idx = paddr[ADDR_W-1:2];
	wire addr_aligned = (paddr[1:0] == 2'b00);
	wire setup_phase = psel && !penable;
	wire access_done = psel && penable && pready_reg;
	wire wr_fire = access_done && pwrite && !pslverr_reg;

	wire [IDX_W-1:0] db_off = idx - DB_MF_IDX;
	wire [IDX_W-1:0] a1_off = idx - ACTIVE1_MF_ALIGN_SPARE_IDX;
	wire [PAIR_W-1:0] db_pair = db_off[PAIR_W-1:0];
	wire [PAIR_W-1:0] a1_pair = a1_off[PAIR_W-1:0];
	wire db_in_range = (idx >= DB_MF_IDX) && (db_off <= {6'h00, PAIR_LAST});
	wire a1_in_range = (idx >= ACTIVE1_MF_ALIGN_SPARE_IDX)
		&& (a1_off <= {6'h00, PAIR_LAST});
	wire db_mf_sel = (idx == DB_MF_IDX);
	wire a1_mf_sel = (idx == ACTIVE1_MF_ALIGN_SPARE_IDX);
	wire db_pair_sel = db_in_range && !db_mf_sel;
	wire a1_pair_sel = a1_in_range && !a1_mf_sel;
	wire ctrl_sel = (idx == CTRL_IDX);
	wire enable_sel = (idx == ENABLE_IDX);
	wire addr_mapped = addr_aligned && (db_in_range || a1_in_range || ctrl_sel || enable_sel);

	wire db_pair_wr = wr_fire && db_pair_sel && pstrb[0];
	wire a1_pair_wr = wr_fire && a1_pair_sel && pstrb[0];
	wire ctrl_wr = wr_fire && ctrl_sel && pstrb[0];
	wire enable_wr = wr_fire && enable_sel;

	wire [NIB_W-1:0] wr_hi_nib = pwdata[NIB_HI_LSB +: NIB_W];
	wire [NIB_W-1:0] wr_lo_nib = pwdata[NIB_LO_LSB +: NIB_W];

	// ------------------------------------------------------------
	// Per-channel buffers
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
			// Frame k carries channel k high and channel k+15 low
			localparam bit IS_HI = (ch < HALF_CH);
			localparam logic [PAIR_W-1:0] PAIR =
				PAIR_W'(IS_HI ? ch + 1 : ch - HALF_CH + 1);
			wire line_hit;
			wire [NIB_W-1:0] line_nib;
			wire debounce_ok;
			wire db_line_we;
			wire db_cpu_we;
			wire a1_cpu_we;
			wire [NIB_W-1:0] cpu_nib;

			assign line_hit = ts16_valid && (ts16_frame == PAIR);
			assign line_nib = IS_HI ? rx_hi_nib : rx_lo_nib;
			// With debounce selected, two equal receptions in a row before the stored state moves
			assign debounce_ok = !debounce_select_reg || (line_nib == a1_q[ch]);
			assign db_line_we = line_hit && chan_rx_sig_update_enable_reg[ch]
				&& debounce_ok;
			assign cpu_nib = IS_HI ? wr_hi_nib : wr_lo_nib;
			assign db_cpu_we = db_pair_wr && (db_pair == PAIR);
			assign a1_cpu_we = a1_pair_wr && (a1_pair == PAIR);

			sig_nibble_cell #(
				.W(NIB_W),
				.RESET_VAL(NIB_RESET)
			) u_db (
				.pclk(pclk),
				.presetn(presetn),
				.cpu_we(db_cpu_we),
				.cpu_d(cpu_nib),
				.line_we(db_line_we),
				.line_d(line_nib),
				.q(db_q[ch])
			);

			// Latest nibble off the line regardless of enable
			sig_nibble_cell #(
				.W(NIB_W),
				.RESET_VAL(NIB_RESET)
			) u_a1 (
				.pclk(pclk),
				.presetn(presetn),
				.cpu_we(a1_cpu_we),
				.cpu_d(cpu_nib),
				.line_we(line_hit),
				.line_d(line_nib),
				.q(a1_q[ch])
			);

			assign rx_highway_sig[ch*NIB_W +: NIB_W] = db_q[ch];
		end
	endgenerate

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	assign debounce_select_next = ctrl_wr ? pwdata[CTRL_DEBOUNCE_POS] : debounce_select_reg;

	always_comb begin
		chan_rx_sig_update_enable_next = chan_rx_sig_update_enable_reg;
		for (int b = 0; b < STRB_W; b++) begin
			for (int i = 0; i < BYTE_W; i++) begin
				if (enable_wr && pstrb[b] && (b*BYTE_W + i < NUM_CH)) begin
					chan_rx_sig_update_enable_next[b*BYTE_W + i] = pwdata[b*BYTE_W + i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire [CH_IDX_W-1:0] db_hi_ch = {1'b0, db_pair} - HI_CH_OFFSET;
	wire [CH_IDX_W-1:0] db_lo_ch = {1'b0, db_pair} + LO_CH_OFFSET;
	wire [CH_IDX_W-1:0] a1_hi_ch = {1'b0, a1_pair} - HI_CH_OFFSET;
	wire [CH_IDX_W-1:0] a1_lo_ch = {1'b0, a1_pair} + LO_CH_OFFSET;

	always_comb begin
		prdata_next = DATA_ZERO;
		if (!addr_mapped) begin
			prdata_next = DATA_ZERO;
		end else if (db_mf_sel) begin
			prdata_next[BYTE_W-1:0] = db_mf_reg;
		end else if (db_pair_sel) begin
			prdata_next[BYTE_W-1:0] = {db_q[db_hi_ch], db_q[db_lo_ch]};
		end else if (a1_mf_sel) begin
			// Stale active buffer reads zero outside debounce mode
			if (debounce_select_reg) begin
				prdata_next[BYTE_W-1:0] = a1_mf_reg;
			end
		end else if (a1_pair_sel) begin
			if (debounce_select_reg) begin
				prdata_next[BYTE_W-1:0] = {a1_q[a1_hi_ch], a1_q[a1_lo_ch]};
			end
		end else if (ctrl_sel) begin
			prdata_next[CTRL_DEBOUNCE_POS] = debounce_select_reg;
		end else begin
			prdata_next[NUM_CH-1:0] = chan_rx_sig_update_enable_reg;
		end
	end

	// One wait-free access phase: answer is ready when penable rises
	assign pready_next = setup_phase;
	assign pslverr_next = setup_phase && !addr_mapped;

	// ------------------------------------------------------------
	// Flops
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_rx_sig_update_enable_reg <= ENABLE_RESET;
			debounce_select_reg <= CTRL_DEBOUNCE_RESET;
			db_mf_reg <= BYTE_RESET;
			a1_mf_reg <= BYTE_RESET;
		end else begin
			chan_rx_sig_update_enable_reg <= chan_rx_sig_update_enable_next;
			debounce_select_reg <= debounce_select_next;
			db_mf_reg <= db_mf_next;
			a1_mf_reg <= a1_mf_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= DATA_ZERO;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			if (setup_phase) begin
				prdata_reg <= prdata_next;
			end
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign active1_valid = debounce_select_reg;

endmodule

/* tb/rx_cas_properties.sv */
`timescale 1ns/1ps

module rx_cas_properties
	import rx_cas_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [STRB_W-1:0] pstrb,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ts16_valid,
	input wire logic [FRAME_W-1:0] ts16_frame,
	input wire logic [BYTE_W-1:0] ts16_byte,
	input wire logic [NUM_CH*NIB_W-1:0] rx_highway_sig,
	input wire logic active1_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	a_ready_once: assert property (s_setup |=> s_answer)
		else $error("pready not one cycle after setup");
	a_no_stray: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	a_err_misalign: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("misaligned access not refused");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside access");
	a_rd_upper: assert property (pready && !pwrite && paddr[11:2] != ENABLE_IDX
		|-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	// ------------------------------------------------------------
	// Buffer behaviour
	// ------------------------------------------------------------
	a_valid_ctrl: assert property ($changed(active1_valid)
		|-> $past(psel && penable && pwrite && paddr[11:2] == CTRL_IDX))
		else $error("active valid changed without control write");
	// Highway moves only on line data or a software write
	a_hwy_hold: assert property (!ts16_valid && !(psel && penable && pwrite)
		|=> $stable(rx_highway_sig))
		else $error("highway changed with no cause");
	a_frame0_keep: assert property (ts16_valid && ts16_frame == MF_FRAME0 && !psel
		|=> $stable(rx_highway_sig))
		else $error("frame 0 byte reached a channel");
endmodule

bind rx_cas_signaling_buffer rx_cas_properties u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ts16_valid,
	.ts16_frame, .ts16_byte, .rx_highway_sig, .active1_valid);

/* tb/ts16_line_model.sv */
`timescale 1ns/1ps

module ts16_line_model
	import rx_cas_pkg::*;
(
	input wire logic pclk,
	output logic ts16_valid,
	output logic [FRAME_W-1:0] ts16_frame,
	output logic [BYTE_W-1:0] ts16_byte
);
	initial begin
		ts16_valid = 1'b0;
		ts16_frame = MF_FRAME0;
		ts16_byte = BYTE_RESET;
	end
	// Bit 7 of the byte is the first bit received in the slot
	task automatic send(input logic [FRAME_W-1:0] f, input logic [BYTE_W-1:0] b);
		@(posedge pclk);
		ts16_valid <= 1'b1;
		ts16_frame <= f;
		ts16_byte <= b;
		@(posedge pclk);
		ts16_valid <= 1'b0;
		// Released line no longer shows the old byte
		ts16_byte <= ~b;
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps

module testbench
	import rx_cas_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [STRB_W-1:0] pstrb = 4'hf;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic ts16_valid;
	logic [FRAME_W-1:0] ts16_frame;
	logic [BYTE_W-1:0] ts16_byte;
	logic [NUM_CH*NIB_W-1:0] rx_highway_sig;
	logic active1_valid;
	logic [31:0] rd;
	logic err;
	logic [7:0] b;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;

	rx_cas_signaling_buffer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ts16_valid(ts16_valid),
		.ts16_frame(ts16_frame), .ts16_byte(ts16_byte), .rx_highway_sig(rx_highway_sig),
		.active1_valid(active1_valid));
	ts16_line_model u_line (.pclk(pclk), .ts16_valid(ts16_valid), .ts16_frame(ts16_frame),
		.ts16_byte(ts16_byte));

	initial begin
		forever #50 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input int i, input logic [31:0] e);
		apb(1'b0, ADDR_W'(i * 4), 32'h0);
		chk("read data", e, rd);
		chk("read error", 32'h0, {31'h0, err});
	endtask
	task automatic hchk(input int c, input logic [3:0] e);
		chk("highway nibble", {28'h0, e}, {28'h0, rx_highway_sig[(c-1)*4 +: 4]});
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_update;
		apb(1'b1, {ENABLE_IDX, 2'b00}, 32'h3fffffff);
		for (int k = 7; k <= 15; k++) begin
			b = {4'(k), ~4'(k)};
			u_line.send(4'(k), b);
			rchk(DB_MF_IDX + k, {24'h0, b});
			hchk(k, b[7:4]);
			hchk(k + 15, b[3:0]);
		end
	endtask
	task automatic t_freeze;
		apb(1'b1, {ENABLE_IDX, 2'b00}, 32'h0);
		u_line.send(4'h9, 8'h3c);
		rchk(RX_SIG_CH9_CH24_IDX, 32'h96);
		apb(1'b1, {RX_SIG_CH9_CH24_IDX, 2'b00}, 32'hc3);
		rchk(RX_SIG_CH9_CH24_IDX, 32'hc3);
		hchk(9, 4'hc);
		hchk(24, 4'h3);
	endtask
	task automatic t_frame0;
		b = 8'h5a;
		u_line.send(MF_FRAME0, b);
		rchk(DB_MF_IDX, {24'h0, b[7:4], b[3], b[2], b[1], b[0]});
		apb(1'b1, {DB_MF_IDX, 2'b00}, 32'hff);
		rchk(DB_MF_IDX, 32'h5a);
		rchk(ACTIVE1_MF_ALIGN_SPARE_IDX, 32'h0);
		// Second pattern tells apart the pairs of low field bits that the first pattern leaves equal
		u_line.send(MF_FRAME0, 8'ha6);
		rchk(DB_MF_IDX, 32'ha6);
	endtask
	task automatic t_debounce;
		apb(1'b1, {ENABLE_IDX, 2'b00}, 32'h3fffffff);
		apb(1'b1, {CTRL_IDX, 2'b00}, 32'h1);
		// Control flop updates at the completing edge, so look one edge later
		@(posedge pclk);
		chk("active valid", 32'h1, {31'h0, active1_valid});
		rchk(ACTIVE1_MF_ALIGN_SPARE_IDX, 32'ha6);
		u_line.send(4'h1, 8'h12);
		rchk(ACTIVE1_SIG_CH1_CH16_IDX, 32'h12);
		rchk(DB_MF_IDX + 1, 32'h0);
		u_line.send(4'h1, 8'h12);
		rchk(DB_MF_IDX + 1, 32'h12);
		hchk(1, 4'h1);
		hchk(16, 4'h2);
		apb(1'b1, {CTRL_IDX, 2'b00}, 32'h0);
		@(posedge pclk);
		chk("active valid", 32'h0, {31'h0, active1_valid});
	endtask
	task automatic t_refuse;
		apb(1'b0, 12'h004, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, {RX_SIG_CH7_CH22_IDX, 2'b01}, 32'hff);
		chk("misaligned error", 32'h1, {31'h0, err});
		rchk(RX_SIG_CH7_CH22_IDX, 32'h78);
	endtask
	task automatic t_strobe;
		// Byte strobe off: pair write ignored
		pstrb <= 4'h0;
		apb(1'b1, {RX_SIG_CH7_CH22_IDX, 2'b00}, 32'h11);
		rchk(RX_SIG_CH7_CH22_IDX, 32'h78);
		// Only the first enable byte is cleared: channels 1 to 8 frozen
		pstrb <= 4'h1;
		apb(1'b1, {ENABLE_IDX, 2'b00}, 32'h0);
		pstrb <= 4'hf;
		rchk(ENABLE_IDX, 32'h3fffff00);
		rchk(CTRL_IDX, 32'h0);
		u_line.send(4'h7, 8'h21);
		rchk(RX_SIG_CH7_CH22_IDX, 32'h71);
		hchk(22, 4'h1);
	endtask
	task automatic t_reset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		hchk(9, 4'h0);
		chk("active valid", 32'h0, {31'h0, active1_valid});
		rchk(RX_SIG_CH7_CH22_IDX, 32'h0);
		rchk(ENABLE_IDX, 32'h0);
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(RX_SIG_CH7_CH22_IDX, 32'h0);
		hchk(7, 4'h0);
		t_update();
		t_freeze();
		t_frame0();
		t_debounce();
		t_refuse();
		t_strobe();
		t_reset();
		stop_test();
	end
endmodule
